// [rtl/tmc_defs.svh]
// Offsets, field positions, reset values and divider constants of the timer control block.
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMC_OFS_MODE 8'h00
`define TMC_OFS_CTRL 8'h04
`define TMC_OFS_COUNT 8'h08
`define TMC_OFS_GRA 8'h0C
`define TMC_OFS_CFG 8'h10

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define TMC_MODE_RUN 7
`define TMC_MODE_RSV_HI 6
`define TMC_MODE_BUF_B 5
`define TMC_MODE_BUF_A 4
`define TMC_MODE_RSV_LO 3
`define TMC_MODE_PWM_D 2
`define TMC_MODE_PWM_C 1
`define TMC_MODE_PWM_B 0
`define TMC_MODE_RSV_MASK 8'h48
`define TMC_MODE_RST 8'h00

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TMC_CTRL_CLR 7
`define TMC_CTRL_CKS_HI 6
`define TMC_CTRL_CKS_LO 4
`define TMC_CTRL_LVL_HI 3
`define TMC_CTRL_LVL_LO 0
`define TMC_CTRL_RST 8'h00

// ----------------------------------------------------------------
// Own configuration register fields
// ----------------------------------------------------------------
`define TMC_CFG_GRA_CAPTURE 0

// ----------------------------------------------------------------
// Clock source codes and divider terminal counts
// ----------------------------------------------------------------
`define TMC_CKS_DIV1 3'h0
`define TMC_CKS_DIV2 3'h1
`define TMC_CKS_DIV4 3'h2
`define TMC_CKS_DIV8 3'h3
`define TMC_CKS_EXT_BIT 2
`define TMC_DIV2_LAST 3'h1
`define TMC_DIV4_LAST 3'h3
`define TMC_DIV8_LAST 3'h7

`endif

// [rtl/tmc_pkg.sv]
// Shared types of the timer control block.
package tmc_pkg;
  typedef logic [15:0] tmc_count_t;
  typedef logic [7:0] tmc_byte_t;
  typedef logic [2:0] tmc_cks_t;
endpackage

// [rtl/tmc_clock_select.sv]
// Count clock selection: prescaled internal ticks, subclock and external rising edges.
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_clock_select (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Selection
  input wire tmc_pkg::tmc_cks_t clockSource,
  input wire logic subclockMode,
  input wire logic subclockTick,
  input wire logic extEvent,
  // Count enable pulse
  output logic countTick
);
  typedef struct packed {
    logic [2:0] div;
    logic extPrev;
    logic tick;
  } tmc_cs_state_t;

  tmc_cs_state_t st_r;
  tmc_cs_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.div = st_r.div + 3'h1;
    st_nxt.extPrev = extEvent;
    // [RULE8] External rising edges.
    if (clockSource[`TMC_CKS_EXT_BIT]) begin
      st_nxt.tick = extEvent & ~st_r.extPrev;
    end else begin
      // [RULE7] Internal prescaled sources.
      case (clockSource)
        // [RULE9] Subclock replaces the system clock.
        `TMC_CKS_DIV1: st_nxt.tick = subclockMode ? subclockTick : 1'b1;
        `TMC_CKS_DIV2: st_nxt.tick = (st_r.div[0] == 1'(`TMC_DIV2_LAST));
        `TMC_CKS_DIV4: st_nxt.tick = (st_r.div[1:0] == 2'(`TMC_DIV4_LAST));
        `TMC_CKS_DIV8: st_nxt.tick = (st_r.div == `TMC_DIV8_LAST);
        default: st_nxt.tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign countTick = st_r.tick;
endmodule

// [rtl/tmc_counter.sv]
// Sixteen-bit timer counter with compare match A and optional clear on that match.
`timescale 1ns/1ps
module tmc_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire logic clearOnMatch,
  input wire logic compareEnable,
  input wire tmc_pkg::tmc_count_t compareValue,
  // State
  output tmc_pkg::tmc_count_t count,
  output logic matchA
);
  typedef struct packed {
    tmc_pkg::tmc_count_t count;
    logic match;
  } tmc_cnt_state_t;

  tmc_cnt_state_t st_r;
  tmc_cnt_state_t st_nxt;
  logic hit;

  always_comb begin
    st_nxt = st_r;
    // [RULE12] Match while register A compares.
    hit = compareEnable && (st_r.count == compareValue);
    st_nxt.match = 1'b0;
    // [RULE1] Count only when started.
    if (run && tick) begin
      st_nxt.match = hit;
      // [RULE6] Clear on match A.
      if (clearOnMatch && hit) begin
        st_nxt.count = '0;
      end else begin
        st_nxt.count = st_r.count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.count;
  assign matchA = st_r.match;
endmodule

// [rtl/tmc_timer_ctrl.sv]
// Timer mode and clock control block with its APB register slave.
// ----------------------------------------------------------------
// Notes on behaviour
// [RULE1] Counter halts while the run bit is 0, counts while 1.
// [RULE2] Mode bits 6 and 3 read as 1 and ignore writes.
// [RULE3] Buffer select B set makes register D the buffer of B.
// [RULE4] Buffer select A set makes register C the buffer of A.
// [RULE5] Mode bits 2, 1, 0 choose PWM or compare output for D, C, B.
// [RULE6] Control bit 7 clears the counter on match A, else free run.
// [RULE7] Clock codes 000 to 011 count on clock divided by 1, 2, 4, 8.
// [RULE8] Clock codes with top bit set count external rising edges.
// [RULE9] Undivided clock in subclock modes counts the subclock instead.
// [RULE10] Control bits 3 to 0 set output levels of pins D to A.
// [RULE11] A written output level shows on its pin straight away.
// [RULE12] Match A when counter equals register A in compare use.
// ----------------------------------------------------------------
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_timer_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip mode and pins
  input wire logic subclockMode,
  input wire logic subclockTick,
  input wire logic externalEventInput,
  // Controls to the capture and compare datapath
  output logic counterRun,
  output logic clearOnMatchA,
  output logic bufferPairBSel,
  output logic bufferPairASel,
  output logic pwmSelPinD,
  output logic pwmSelPinC,
  output logic pwmSelPinB,
  output logic [3:0] outLevel,
  output logic generalRegAIsCapture,
  // Counter state
  output tmc_pkg::tmc_count_t timerCounter,
  output logic compareMatchA
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tmc_pkg::tmc_byte_t mode;
    tmc_pkg::tmc_byte_t ctrl;
    tmc_pkg::tmc_count_t general_reg_a;
    logic graCapture;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } tmc_state_t;

  tmc_state_t st_r;
  tmc_state_t st_nxt;
  logic countTick;
  tmc_pkg::tmc_count_t count;
  logic matchA;
  logic setup;
  logic wrDone;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == `TMC_OFS_MODE) || (a == `TMC_OFS_CTRL) || (a == `TMC_OFS_COUNT) ||
                 (a == `TMC_OFS_GRA) || (a == `TMC_OFS_CFG);
  endfunction

  // ----------------------------------------------------------------
  // Register file and bus answer
  // ----------------------------------------------------------------
  // The answer is prepared at the setup edge so that read data and
  // pready both come from flip-flops; every access takes one wait-free
  // access phase.
  always_comb begin
    st_nxt = st_r;
    setup = psel && !penable;
    wrDone = psel && penable && st_r.ready && pwrite && known_addr(paddr);
    st_nxt.ready = setup;
    st_nxt.err = setup && !known_addr(paddr);
    st_nxt.rdata = '0;
    if (setup && !pwrite) begin
      case (paddr)
        // [RULE2] Reserved mode bits read as 1.
        `TMC_OFS_MODE: st_nxt.rdata = {24'h000000, st_r.mode | `TMC_MODE_RSV_MASK};
        `TMC_OFS_CTRL: st_nxt.rdata = {24'h000000, st_r.ctrl};
        `TMC_OFS_COUNT: st_nxt.rdata = {16'h0000, count};
        `TMC_OFS_GRA: st_nxt.rdata = {16'h0000, st_r.general_reg_a};
        `TMC_OFS_CFG: st_nxt.rdata = {31'h00000000, st_r.graCapture};
        default: st_nxt.rdata = '0;
      endcase
    end
    if (wrDone) begin
      case (paddr)
        // [RULE2] Reserved mode bits ignore writes.
        `TMC_OFS_MODE: st_nxt.mode = pwdata[7:0] & ~`TMC_MODE_RSV_MASK;
        // [RULE11] Level bits take effect at once.
        `TMC_OFS_CTRL: st_nxt.ctrl = pwdata[7:0];
        `TMC_OFS_GRA: st_nxt.general_reg_a = pwdata[15:0];
        `TMC_OFS_CFG: st_nxt.graCapture = pwdata[`TMC_CFG_GRA_CAPTURE];
        default: st_nxt.mode = st_r.mode;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r.mode <= `TMC_MODE_RST;
      st_r.ctrl <= `TMC_CTRL_RST;
      st_r.general_reg_a <= '0;
      st_r.graCapture <= 1'b0;
      st_r.rdata <= '0;
      st_r.ready <= 1'b0;
      st_r.err <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Count clock and counter
  // ----------------------------------------------------------------
  // [RULE7] Clock source decode.
  tmc_clock_select u_clock_select (
    .clk(clk),
    .rstn(rstn),
    .clockSource(st_r.ctrl[`TMC_CTRL_CKS_HI:`TMC_CTRL_CKS_LO]),
    .subclockMode(subclockMode),
    .subclockTick(subclockTick),
    .extEvent(externalEventInput),
    .countTick(countTick)
  );

  // [RULE1] Run bit gates counting.
  tmc_counter u_counter (
    .clk(clk),
    .rstn(rstn),
    .run(st_r.mode[`TMC_MODE_RUN]),
    .tick(countTick),
    .clearOnMatch(st_r.ctrl[`TMC_CTRL_CLR]),
    .compareEnable(!st_r.graCapture),
    .compareValue(st_r.general_reg_a),
    .count(count),
    .matchA(matchA)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;
  assign counterRun = st_r.mode[`TMC_MODE_RUN];
  assign clearOnMatchA = st_r.ctrl[`TMC_CTRL_CLR];
  // [RULE3] Register D buffers register B.
  assign bufferPairBSel = st_r.mode[`TMC_MODE_BUF_B];
  // [RULE4] Register C buffers register A.
  assign bufferPairASel = st_r.mode[`TMC_MODE_BUF_A];
  // [RULE5] PWM selection per pin.
  assign pwmSelPinD = st_r.mode[`TMC_MODE_PWM_D];
  assign pwmSelPinC = st_r.mode[`TMC_MODE_PWM_C];
  assign pwmSelPinB = st_r.mode[`TMC_MODE_PWM_B];
  // [RULE10] Output levels D, C, B, A.
  assign outLevel = st_r.ctrl[`TMC_CTRL_LVL_HI:`TMC_CTRL_LVL_LO];
  assign generalRegAIsCapture = st_r.graCapture;
  assign timerCounter = count;
  assign compareMatchA = matchA;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_counter_halt: assert property (!counterRun |=> $stable(timerCounter)) // [RULE1]
    else $error("Counter moved while halted.");

  a_reserved_read: assert property (
    psel && !penable && !pwrite && paddr == `TMC_OFS_MODE
    |=> prdata[`TMC_MODE_RSV_HI] && prdata[`TMC_MODE_RSV_LO] && pready) // [RULE2]
    else $error("Reserved mode bits did not read as one.");

  a_buf_b_write: assert property (
    psel && penable && pready && pwrite && paddr == `TMC_OFS_MODE
    |=> bufferPairBSel == $past(pwdata[`TMC_MODE_BUF_B]) && counterRun ==
        $past(pwdata[`TMC_MODE_RUN])) // [RULE3]
    else $error("Buffer B select or run bit not taken from write.");

  a_buf_a_write: assert property (
    psel && penable && pready && pwrite && paddr == `TMC_OFS_MODE
    |=> bufferPairASel == $past(pwdata[`TMC_MODE_BUF_A])) // [RULE4]
    else $error("Buffer A select not taken from write.");

  a_pwm_write: assert property (
    psel && penable && pready && pwrite && paddr == `TMC_OFS_MODE
    |=> {pwmSelPinD, pwmSelPinC, pwmSelPinB} == $past(pwdata[2:0])) // [RULE5]
    else $error("PWM selects not taken from write.");

  a_clear_match: assert property (
    compareMatchA && clearOnMatchA && $past(clearOnMatchA) |-> timerCounter == 16'h0000) // [RULE6]
    else $error("Counter not cleared on match A.");

  a_free_run: assert property (
    compareMatchA && !$past(clearOnMatchA) |-> timerCounter == $past(timerCounter) + 16'h0001) // [RULE6]
    else $error("Free-running counter did not advance past match A.");

  a_div8_rate: assert property (
    counterRun && clearOnMatchA == 1'b0
    && st_r.ctrl[`TMC_CTRL_CKS_HI:`TMC_CTRL_CKS_LO] == `TMC_CKS_DIV8
    && $changed(timerCounter)
    ##1 (counterRun && st_r.ctrl[`TMC_CTRL_CKS_HI:`TMC_CTRL_CKS_LO] == `TMC_CKS_DIV8) [*7]
    |-> $stable(timerCounter)) // [RULE7]
    else $error("Divide-by-eight source counted too fast.");

  a_ext_idle: assert property (
    st_r.ctrl[`TMC_CTRL_CKS_HI] && !externalEventInput [*3] |=> $stable(timerCounter)) // [RULE8]
    else $error("Counter moved without external edges.");

  a_sub_idle: assert property (
    st_r.ctrl[`TMC_CTRL_CKS_HI:`TMC_CTRL_CKS_LO] == `TMC_CKS_DIV1 && subclockMode
    && !subclockTick [*3]
    |=> $stable(timerCounter)) // [RULE9]
    else $error("Counter moved without subclock ticks.");

  a_level_write: assert property (
    psel && penable && pready && pwrite && paddr == `TMC_OFS_CTRL
    |=> outLevel == $past(pwdata[3:0])) // [RULE11]
    else $error("Output level not updated on the cycle after write.");

  a_match_cause: assert property (
    compareMatchA |-> !$past(generalRegAIsCapture)
    && $past(timerCounter) == $past(st_r.general_reg_a)) // [RULE12]
    else $error("Match A without counter equal to register A.");
endmodule

// [test/tmc_timer_ctrl_tb.sv]
// Self-checking bench for the timer mode and clock control block.
`timescale 1ns/1ps
`include "tmc_defs.svh"
module tmc_timer_ctrl_tb;
  logic clk, rstn, psel, penable, pwrite, subclockMode, subclockTick, extEv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err;
  logic counterRun, clearOnMatchA, bufB, bufA, pwm_sel_pin_d, pwm_sel_pin_c, pwm_sel_pin_b, gaCap, matchA;
  logic [3:0] outLevel;
  tmc_pkg::tmc_count_t cnt, c0, c1;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int p, m;

  tmc_timer_ctrl dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subclockMode(subclockMode), .subclockTick(subclockTick),
    .externalEventInput(extEv), .counterRun(counterRun), .clearOnMatchA(clearOnMatchA),
    .bufferPairBSel(bufB), .bufferPairASel(bufA), .pwmSelPinD(pwm_sel_pin_d), .pwmSelPinC(pwm_sel_pin_c),
    .pwmSelPinB(pwm_sel_pin_b), .outLevel(outLevel), .generalRegAIsCapture(gaCap),
    .timerCounter(cnt), .compareMatchA(matchA));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Entered right after a rising edge; returns one idle edge after the one that
  // sampled pready, so a following transfer never reassigns psel in one step.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    chk(pready, 1'h1, "bus answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task watch(input int n);
    p = 0;
    m = 0;
    repeat (n) begin
      @(posedge clk);
      if (matchA === 1'h1) p++;
      if (cnt > m) m = cnt;
    end
  endtask

  task rdcnt(output tmc_pkg::tmc_count_t c);
    repeat (4) @(posedge clk);
    apb(1'h0, `TMC_OFS_COUNT, 32'h0);
    c = rd[15:0];
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    apb(1'h0, `TMC_OFS_MODE, 32'h0);
    chk(rd, 32'h48, "mode reset value");
    apb(1'h0, `TMC_OFS_CTRL, 32'h0);
    chk(rd, 32'h0, "control reset value");
    apb(1'h0, 8'h40, 32'h0);
    chk(err, 1'h1, "unmapped address error");
    $display("test reset done");
  endtask

  task t_match;
    apb(1'h1, `TMC_OFS_GRA, 32'h2);
    apb(1'h1, `TMC_OFS_CFG, 32'h0);
    apb(1'h1, `TMC_OFS_CTRL, 32'h80);
    apb(1'h1, `TMC_OFS_MODE, 32'h80);
    watch(30);
    apb(1'h1, `TMC_OFS_MODE, 32'h0);
    chk(m, 2, "counter cleared at match");
    chk(p, 10, "match pulses per period");
    apb(1'h1, `TMC_OFS_CTRL, 32'h0);
    apb(1'h1, `TMC_OFS_MODE, 32'h80);
    watch(12);
    apb(1'h1, `TMC_OFS_MODE, 32'h0);
    chk(p, 1, "single match when free");
    chk(m >= 10, 1'h1, "free run passes match");
    $display("test match done");
  endtask

  task t_capture;
    rdcnt(c0);
    apb(1'h1, `TMC_OFS_GRA, {16'h0, c0 + 16'h4});
    apb(1'h1, `TMC_OFS_CFG, 32'h1);
    chk(gaCap, 1'h1, "capture use flag");
    apb(1'h1, `TMC_OFS_MODE, 32'h80);
    watch(12);
    apb(1'h1, `TMC_OFS_MODE, 32'h0);
    apb(1'h1, `TMC_OFS_CFG, 32'h0);
    chk(p, 0, "no match in capture use");
    $display("test capture done");
  endtask

  task t_mode;
    logic [7:0] v[7];
    v = '{8'h00, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01, 8'hFF};
    foreach (v[i]) begin
      apb(1'h1, `TMC_OFS_MODE, {24'h0, v[i]});
      apb(1'h0, `TMC_OFS_MODE, 32'h0);
      chk(rd, {24'h0, v[i] | 8'h48}, "mode readback");
      chk(counterRun, v[i][7], "run flag");
      chk(bufB, v[i][5], "buffer pair B");
      chk(bufA, v[i][4], "buffer pair A");
      chk({pwm_sel_pin_d, pwm_sel_pin_c, pwm_sel_pin_b}, v[i][2:0], "pwm selects");
    end
    apb(1'h1, `TMC_OFS_MODE, 32'h0);
    $display("test mode done");
  endtask

  task t_levels;
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, `TMC_OFS_CTRL, 32'h80 | (32'h1 << i));
      chk(outLevel, 4'h1 << i, "level right after write");
      @(posedge clk);
      apb(1'h0, `TMC_OFS_CTRL, 32'h0);
      chk(rd, 32'h80 | (32'h1 << i), "control readback");
      chk(clearOnMatchA, 1'h1, "clear flag");
    end
    $display("test levels done");
  endtask

  // Run window is 64 edges: the write's idle edge, 61 idle, setup and access of the halt.
  task t_div;
    int e;
    for (int k = 0; k < 4; k++) begin
      apb(1'h1, `TMC_OFS_CTRL, k << 4);
      rdcnt(c0);
      apb(1'h1, `TMC_OFS_MODE, 32'h80);
      repeat (61) @(posedge clk);
      apb(1'h1, `TMC_OFS_MODE, 32'h0);
      rdcnt(c1);
      e = 64 >> k;
      chk((c1 - c0) >= e - 1 && (c1 - c0) <= e + 1, 1'h1, "divided rate");
      rdcnt(c0);
      chk(c0, c1, "halted counter holds");
    end
    $display("test divider done");
  endtask

  task t_ext;
    for (int k = 4; k < 8; k++) begin
      apb(1'h1, `TMC_OFS_CTRL, k << 4);
      rdcnt(c0);
      apb(1'h1, `TMC_OFS_MODE, 32'h80);
      repeat (5) begin
        extEv <= 1'h1;
        repeat (2) @(posedge clk);
        extEv <= 1'h0;
        repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      apb(1'h1, `TMC_OFS_MODE, 32'h0);
      rdcnt(c1);
      chk(c1 - c0, 16'h5, "external edge count");
    end
    $display("test external done");
  endtask

  task t_sub;
    apb(1'h1, `TMC_OFS_CTRL, 32'h0);
    subclockMode <= 1'h1;
    rdcnt(c0);
    apb(1'h1, `TMC_OFS_MODE, 32'h80);
    repeat (6) begin
      subclockTick <= 1'h1;
      @(posedge clk);
      subclockTick <= 1'h0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    apb(1'h1, `TMC_OFS_MODE, 32'h0);
    rdcnt(c1);
    chk(c1 - c0, 16'h6, "subclock count");
    subclockMode <= 1'h0;
    $display("test subclock done");
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The whole sequence needs about 800 cycles, so 20000 leaves ample margin.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[FAIL] %0t run did not complete", $time);
      tally_and_finish;
    end
  end

  initial begin
    {rstn, psel, penable, pwrite, subclockMode, subclockTick, extEv} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    chk({counterRun, clearOnMatchA, bufB, bufA, outLevel, matchA}, 32'h0, "reset outputs");
    rstn <= 1'h1;
    @(posedge clk);
    t_reset;
    t_match;
    t_capture;
    t_mode;
    t_levels;
    t_div;
    t_ext;
    t_sub;
    tally_and_finish;
  end
endmodule
